// >>> hdl/ptri_pkg.sv
// shared constants and types of the path pointer interpreter
package ptri_pkg;
  // pointer word layout
  localparam int          FLAG_HI    = 15;
  localparam int          FLAG_LO    = 12;
  localparam int          SS_HI      = 11;
  localparam int          SS_LO      = 10;
  localparam int          PV_HI      = 9;
  localparam logic [3:0]  FLAG_NDF   = 4'h9;
  localparam logic [3:0]  FLAG_NORM  = 4'h6;
  localparam logic [1:0]  SS_SDH     = 2'h2;
  localparam logic [9:0]  PTR_MAX    = 10'h30e;
  localparam logic [9:0]  PTR_ZERO   = 10'h000;
  localparam logic [9:0]  PTR_ONES   = 10'h3ff;
  localparam logic [15:0] AIS_WORD   = 16'hffff;
  localparam logic [9:0]  I_MASK     = 10'h2aa;
  localparam logic [9:0]  D_MASK     = 10'h155;
  // majority thresholds and persistence in frames
  localparam logic [3:0]  SONET_MIN  = 4'h8;
  localparam logic [3:0]  SDH_MIN    = 4'h3;
  localparam logic [3:0]  SDH_MAX    = 4'h2;
  localparam logic [3:0]  FLAG_MIN   = 4'h3;
  localparam logic [3:0]  N_NORM     = 4'h3;
  localparam logic [3:0]  N_AIS      = 4'h3;
  localparam logic [3:0]  N_LOP      = 4'h8;
  localparam logic [3:0]  N_HOLD     = 4'h3;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_STAT  = 8'h04;
  localparam logic [7:0]  ADDR_PEND  = 8'h08;
  localparam logic [7:0]  ADDR_MASK  = 8'h0c;
  localparam logic [7:0]  ADDR_STATE = 8'h10;
  // bit positions
  localparam int          B_AIS      = 0;
  localparam int          B_LOP      = 1;
  localparam int          B_MODE     = 0;
  localparam int          B_PTR      = 16;
  // concatenation indication classes
  localparam logic [1:0]  CI_NORMAL  = 2'h1;
  localparam logic [1:0]  CI_AIS     = 2'h2;
  localparam logic [1:0]  CI_BAD     = 2'h3;

  typedef enum logic [1:0] {ST_NORM, ST_LOP, ST_AIS} ptri_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ptri_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ptri_apb_rsp_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } ptri_word_s;
endpackage

// >>> hdl/ptri_core.sv
// path pointer interpreter with apb register slave
// Functional notes
// [RQ1] concatenation word with near-ndf flag, all-ones value, ss ok is normal ci
// [RQ2] concatenation word equal to the ais word is an ais ci
// [RQ3] any other concatenation word is an invalid ci
// [RQ4] after inc, dec or ndf, refuse inc/dec for three frames
// [RQ5] sonet increment: eight of ten bits match pointer with i bits inverted
// [RQ6] sonet decrement: eight of ten bits match pointer with d bits inverted
// [RQ7] sdh increment: three or more i inverted, at most two d inverted
// [RQ8] sdh decrement: three or more d inverted, at most two i inverted
// [RQ9] sdh: three i and three d inverted gives no adjustment
// [RQ10] machine has three states: normal, loss of pointer, alarm
// [RQ11] one in-range ndf frame from normal or alarm adopts pointer, goes normal
// [RQ12] three equal in-range normal pointers go to normal from any state
// [RQ13] three all-ones words from normal or loss go to alarm
// [RQ14] eight invalid pointers from normal or alarm go to loss of pointer
// [RQ15] one valid inc/dec frame adjusts the current pointer
// [RQ16] in alarm state only the all-ones word counts as valid
// [RQ17] in normal, a normal pointer equal to current counts as valid
// [RQ18] alarm state entry or exit sets latch-high bit, read returns status next
// [RQ19] alarm state change sets pending bit until read, masks route to two irqs
// [RQ20] loss state entry or exit sets latch-high bit, read returns status next
// [RQ21] loss state change sets pending bit until read, masks route to two irqs
// [RQ22] flag bits 15:12; ndf is three of four 1001, normal three of 0110
// [RQ23] sdh compares ss bits 11:10 against 10; sonet ignores them
// [RQ24] a mode bit selects sonet or sdh rules
// [RQ25] normal flag with i bits inverted is increment, d bits inverted decrement
// [RQ26] one primary pointer word per frame, counters step once per frame
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ptri_core
  import ptri_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire ptri_apb_req_s apb_req,
  output var  ptri_apb_rsp_s apb_rsp,
  input  wire ptri_word_s    primary,
  input  wire ptri_word_s    conc,
  output var  logic [1:0]    ci_class,
  output var  logic [1:0]    ptr_state,
  output var  logic          framer_irq_a,
  output var  logic          framer_irq_b
);
  typedef struct packed {
    ptri_state_e   st;
    logic [9:0]    cur;
    logic [9:0]    cand;
    logic [3:0]    cand_cnt;
    logic [3:0]    ais_cnt;
    logic [3:0]    inv_cnt;
    logic [3:0]    hold;
    logic          sdh;
    logic          path_alarm_latched;
    logic          pointer_loss_latched;
    logic          path_alarm_pending;
    logic          pointer_loss_pending;
    logic          path_alarm_mask_irq_a;
    logic          path_alarm_mask_irq_b;
    logic          pointer_loss_mask_irq_a;
    logic          pointer_loss_mask_irq_b;
    logic          irq_a;
    logic          irq_b;
    logic [1:0]    ci;
    ptri_apb_rsp_s rsp;
  } ptri_regs_s;

  ptri_regs_s q;
  ptri_regs_s next_q;

  // population count of a ten bit field
  function automatic logic [3:0] ones10(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 10; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  // three-of-four flag match
  function automatic logic flag_hit(input logic [3:0] f, input logic [3:0] code);
    logic [3:0] m;
    m = ~(f ^ code);
    return ({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]}) >= FLAG_MIN[2:0];
  endfunction

  // word decode, shared by the state machine and the checks
  logic [9:0] pv;
  logic       ss_ok;
  logic       ndf_en;
  logic       norm_fl;
  logic       ais_ptr;
  logic       in_rng;
  logic [3:0] inv_i;
  logic [3:0] inv_d;
  logic       is_inc;
  logic       is_dec;
  logic       ndf_ok;
  logic       norm_ok;
  logic       adj_fl;
  logic       just_ok;
  logic       valid_ptr;
  logic       fr;
  logic       rd_done;
  logic       wr_done;

  assign fr      = primary.valid;  // one primary word per frame [RQ26]
  assign pv      = primary.word[PV_HI:0];
  assign ss_ok   = !q.sdh || primary.word[SS_HI:SS_LO] == SS_SDH;  // [RQ23] [RQ24]
  assign ndf_en  = flag_hit(primary.word[FLAG_HI:FLAG_LO], FLAG_NDF);  // [RQ22]
  assign norm_fl = flag_hit(primary.word[FLAG_HI:FLAG_LO], FLAG_NORM);  // [RQ22]
  assign ais_ptr = primary.word == AIS_WORD;
  assign in_rng  = pv <= PTR_MAX;
  assign inv_i   = ones10((pv ^ q.cur) & I_MASK);
  assign inv_d   = ones10((pv ^ q.cur) & D_MASK);
  // sonet counts matches against the ideal pattern; sdh votes per field
  assign is_inc  = q.sdh ? (inv_i >= SDH_MIN && inv_d <= SDH_MAX)  // [RQ7] [RQ9]
                         : (ones10(~(pv ^ q.cur ^ I_MASK)) >= SONET_MIN);  // [RQ5] [RQ25]
  assign is_dec  = q.sdh ? (inv_d >= SDH_MIN && inv_i <= SDH_MAX)  // [RQ8] [RQ9]
                         : (ones10(~(pv ^ q.cur ^ D_MASK)) >= SONET_MIN);  // [RQ6] [RQ25]
  assign ndf_ok  = ndf_en && in_rng && ss_ok;
  assign norm_ok = norm_fl && in_rng && ss_ok;
  // an inverted-bit word may lie above the pointer range, so adjustments
  // need only the normal flag and the ss match, not the range check
  assign adj_fl  = norm_fl && ss_ok;  // [RQ25]
  // a refused adjustment still counts as valid so it cannot drive loss
  assign just_ok = q.st == ST_NORM && adj_fl && pv != q.cur && (is_inc || is_dec)
                   && q.hold == 4'h0;  // [RQ4] [RQ15]
  // valid-pointer view used by the loss counter and by the loss entry check
  always_comb begin
    case (q.st)
      ST_AIS:  valid_ptr = ais_ptr;  // [RQ16]
      ST_NORM: valid_ptr = ndf_ok || (norm_ok && pv == q.cur)
                           || (adj_fl && (is_inc || is_dec));  // [RQ17]
      default: valid_ptr = 1'b0;
    endcase
  end

  assign rd_done = apb_req.psel && apb_req.penable && q.rsp.pready && !apb_req.pwrite;
  assign wr_done = apb_req.psel && apb_req.penable && q.rsp.pready && apb_req.pwrite;

  // next-state: pointer machine, alarm latches and the register slave
  always_comb begin
    logic ais_chg;
    logic lop_chg;
    next_q = q;
    ais_chg = 1'b0;
    lop_chg = 1'b0;
    if (fr) begin
      next_q.hold     = (q.hold != 4'h0) ? q.hold - 4'h1 : 4'h0;
      next_q.cand     = pv;
      next_q.cand_cnt = !norm_ok ? 4'h0 :
                        (pv == q.cand && q.cand_cnt != N_NORM) ? q.cand_cnt + 4'h1 :
                        (pv == q.cand) ? N_NORM : 4'h1;
      next_q.ais_cnt  = !ais_ptr ? 4'h0 : (q.ais_cnt != N_AIS) ? q.ais_cnt + 4'h1 : N_AIS;
      next_q.inv_cnt  = (valid_ptr || q.st == ST_LOP) ? 4'h0 :
                        (q.inv_cnt != N_LOP) ? q.inv_cnt + 4'h1 : N_LOP;
      if (ndf_ok && q.st != ST_LOP) begin
        next_q.st   = ST_NORM;  // [RQ11]
        next_q.cur  = pv;
        next_q.hold = N_HOLD;  // [RQ4]
      end else if (next_q.cand_cnt == N_NORM) begin
        next_q.st  = ST_NORM;  // [RQ12]
        next_q.cur = pv;
      end else if (next_q.ais_cnt == N_AIS && q.st != ST_AIS) begin
        next_q.st = ST_AIS;  // [RQ13]
      end else if (next_q.inv_cnt == N_LOP && q.st != ST_LOP) begin
        next_q.st      = ST_LOP;  // [RQ14]
        next_q.inv_cnt = 4'h0;
      end else if (just_ok) begin
        next_q.hold = N_HOLD;  // [RQ4] [RQ15]
        if (is_inc) begin
          next_q.cur = (q.cur == PTR_MAX) ? PTR_ZERO : q.cur + 10'h001;
        end else begin
          next_q.cur = (q.cur == PTR_ZERO) ? PTR_MAX : q.cur - 10'h001;
        end
      end
      ais_chg = (next_q.st == ST_AIS) != (q.st == ST_AIS);
      lop_chg = (next_q.st == ST_LOP) != (q.st == ST_LOP);
    end
    // concatenation word classification [RQ1] [RQ2] [RQ3]
    if (conc.valid) begin
      if (conc.word == AIS_WORD) begin
        next_q.ci = CI_AIS;
      end else if (flag_hit(conc.word[FLAG_HI:FLAG_LO], FLAG_NDF)
                   && conc.word[PV_HI:0] == PTR_ONES
                   && (!q.sdh || conc.word[SS_HI:SS_LO] == SS_SDH)) begin
        next_q.ci = CI_NORMAL;
      end else begin
        next_q.ci = CI_BAD;
      end
    end
    // latch-high bits reload current status on read; a new event wins
    if (rd_done && apb_req.paddr == ADDR_STAT) begin
      next_q.path_alarm_latched   = q.st == ST_AIS;
      next_q.pointer_loss_latched = q.st == ST_LOP;
    end
    if (rd_done && apb_req.paddr == ADDR_PEND) begin
      next_q.path_alarm_pending   = 1'b0;
      next_q.pointer_loss_pending = 1'b0;
    end
    if (ais_chg) begin
      next_q.path_alarm_latched = 1'b1;  // [RQ18]
      next_q.path_alarm_pending = 1'b1;  // [RQ19]
    end
    if (lop_chg) begin
      next_q.pointer_loss_latched = 1'b1;  // [RQ20]
      next_q.pointer_loss_pending = 1'b1;  // [RQ21]
    end
    if (wr_done && apb_req.paddr == ADDR_CTRL) begin
      next_q.sdh = apb_req.pwdata[B_MODE];  // [RQ24]
    end
    if (wr_done && apb_req.paddr == ADDR_MASK) begin
      next_q.path_alarm_mask_irq_a   = apb_req.pwdata[0];
      next_q.path_alarm_mask_irq_b   = apb_req.pwdata[1];
      next_q.pointer_loss_mask_irq_a = apb_req.pwdata[2];
      next_q.pointer_loss_mask_irq_b = apb_req.pwdata[3];
    end
    // interrupt lines follow pending bits one cycle later [RQ19] [RQ21]
    next_q.irq_a = (q.path_alarm_pending && q.path_alarm_mask_irq_a)
                || (q.pointer_loss_pending && q.pointer_loss_mask_irq_a);
    next_q.irq_b = (q.path_alarm_pending && q.path_alarm_mask_irq_b)
                || (q.pointer_loss_pending && q.pointer_loss_mask_irq_b);
    // answer in the cycle after setup, so every access takes two cycles
    next_q.rsp.pready  = apb_req.psel && !apb_req.penable;
    next_q.rsp.pslverr = 1'b0;
    next_q.rsp.prdata  = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable) begin
      case (apb_req.paddr)
        ADDR_CTRL:  next_q.rsp.prdata[B_MODE] = q.sdh;
        ADDR_STAT: begin
          next_q.rsp.prdata[B_AIS] = q.path_alarm_latched;
          next_q.rsp.prdata[B_LOP] = q.pointer_loss_latched;
        end
        ADDR_PEND: begin
          next_q.rsp.prdata[B_AIS] = q.path_alarm_pending;
          next_q.rsp.prdata[B_LOP] = q.pointer_loss_pending;
        end
        ADDR_MASK:  next_q.rsp.prdata[3:0] = {q.pointer_loss_mask_irq_b,
                                              q.pointer_loss_mask_irq_a,
                                              q.path_alarm_mask_irq_b,
                                              q.path_alarm_mask_irq_a};
        ADDR_STATE: begin
          next_q.rsp.prdata[1:0]           = q.st;
          next_q.rsp.prdata[B_PTR +: 10]   = q.cur;
        end
        default:    next_q.rsp.pslverr = 1'b1;
      endcase
    end
  end

  // single register stage; start in loss of pointer until a pointer is seen [RQ10]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q    <= '0;
      q.st <= ST_LOP;
    end else begin
      q <= next_q;
    end
  end

  assign apb_rsp      = q.rsp;
  assign ci_class     = q.ci;
  assign ptr_state    = q.st;
  assign framer_irq_a = q.irq_a;
  assign framer_irq_b = q.irq_b;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ndf_frame;
    fr && ndf_ok && q.st != ST_LOP;
  endsequence
  sequence s_third_ais;
    fr && ais_ptr && q.ais_cnt == 4'h2 && q.st != ST_AIS;
  endsequence
  sequence s_adjust;
    fr && q.st == ST_NORM && next_q.st == ST_NORM && q.cur != next_q.cur
      && !(ndf_ok) && next_q.cand_cnt != N_NORM;
  endsequence

  AST_NDF_ADOPT: assert property (s_ndf_frame |=> q.st == ST_NORM && q.cur == $past(pv))  // [RQ11]
    else $error("ndf frame not adopted");
  AST_AIS_ENTRY: assert property (s_third_ais |=> q.st == ST_AIS)  // [RQ13]
    else $error("third ais word did not enter alarm");
  AST_HOLD_OFF: assert property (s_adjust |=> (!(fr && just_ok)) [*3])  // [RQ4]
    else $error("adjustment accepted inside hold-off");
  // a third equal normal pointer may still adopt the word; only adjustment is barred
  AST_SDH_BOTH: assert property (fr && q.sdh && inv_i >= SDH_MIN && inv_d >= SDH_MIN
                                 && !ndf_ok && next_q.cand_cnt != N_NORM
                                 |=> q.cur == $past(q.cur))  // [RQ9]
    else $error("pointer moved on ambiguous sdh word");
  AST_LOP_ENTRY: assert property (fr && q.st != ST_LOP && !valid_ptr && q.inv_cnt == 4'h7
                                  && !ais_ptr && !norm_ok && !ndf_ok |=> q.st == ST_LOP)  // [RQ14]
    else $error("eighth invalid pointer did not enter loss");
  AST_AIS_PEND: assert property ((q.st == ST_AIS) != ($past(q.st) == ST_AIS)
                                 |-> q.path_alarm_pending && q.path_alarm_latched)  // [RQ19]
    else $error("alarm change not latched");
  AST_LOP_PEND: assert property ((q.st == ST_LOP) != ($past(q.st) == ST_LOP)
                                 |-> q.pointer_loss_pending && q.pointer_loss_latched)  // [RQ21]
    else $error("loss change not latched");
  AST_IRQ_A: assert property (q.path_alarm_pending && q.path_alarm_mask_irq_a
                              |=> framer_irq_a)  // [RQ19]
    else $error("irq a not raised");
  AST_CI_AIS: assert property (conc.valid && conc.word == AIS_WORD |=> ci_class == CI_AIS)  // [RQ2]
    else $error("ais ci misclassified");

  // further checks on the outputs that software and the interrupt lines see, and on the loss counter
  AST_IRQ_B: assert property (q.pointer_loss_pending && q.pointer_loss_mask_irq_b
                              |=> framer_irq_b)  // [RQ21]
    else $error("irq b not raised");
  AST_IRQ_QUIET: assert property (!((q.path_alarm_pending && q.path_alarm_mask_irq_a)
                                  || (q.pointer_loss_pending && q.pointer_loss_mask_irq_a))
                                  |=> !framer_irq_a)  // [RQ19]
    else $error("irq a raised with nothing pending");
  // the slave answers in the access cycle and never stretches it
  AST_READY_ONE: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  AST_READY_LOW: assert property (apb_req.psel && apb_req.penable |=> !apb_rsp.pready)
    else $error("ready held past access");
  AST_PSLVERR: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr > ADDR_STATE
                                |=> apb_rsp.pslverr)
    else $error("unmapped address not refused");
  AST_CI_NORMAL: assert property (conc.valid && conc.word != AIS_WORD
                                  && flag_hit(conc.word[FLAG_HI:FLAG_LO], FLAG_NDF)
                                  && conc.word[PV_HI:0] == PTR_ONES
                                  && (!q.sdh || conc.word[SS_HI:SS_LO] == SS_SDH)
                                  |=> ci_class == CI_NORMAL)  // [RQ1]
    else $error("normal ci misclassified");
  AST_CI_BAD: assert property (conc.valid && conc.word != AIS_WORD
                               && !flag_hit(conc.word[FLAG_HI:FLAG_LO], FLAG_NDF)
                               |=> ci_class == CI_BAD)  // [RQ3]
    else $error("invalid ci not flagged");
  AST_AIS_VALID: assert property (fr && q.st == ST_AIS && ais_ptr |=> q.inv_cnt == 4'h0)  // [RQ16]
    else $error("alarm word counted invalid in alarm state");
  AST_STATE_LEGAL: assert property (ptr_state != 2'h3)  // [RQ10]
    else $error("pointer machine left its three states");
  // hold-off must be reloaded by every accepted adjustment and new data flag
  AST_HOLD_LOAD: assert property (s_adjust |=> q.hold == N_HOLD)  // [RQ4]
    else $error("hold-off not loaded after adjustment");
  AST_NDF_HOLD: assert property (s_ndf_frame |=> q.hold == N_HOLD)  // [RQ4]
    else $error("hold-off not loaded after ndf");
endmodule
`default_nettype wire

// >>> test/ptri_far_end.sv
// far-end transmitter model: one pointer word per frame pulse
`timescale 1ns/1ns
`default_nettype none
module ptri_far_end
  import ptri_pkg::*;
(
  input  wire logic       clk,
  output var  ptri_word_s primary,
  output var  ptri_word_s conc
);
  initial begin
    primary = '0;
    conc    = '0;
  end
  // one-cycle valid, then the word line shows the inverse of the last word
  // so a stale value can never pass for a fresh one
  task automatic send(input logic to_conc, input logic [15:0] w);
    @(posedge clk);
    if (to_conc) conc <= '{1'b1, w};
    else primary <= '{1'b1, w};
    @(posedge clk);
    primary <= '{1'b0, ~w};
    conc    <= '{1'b0, ~w};
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/sonet_sdh_pointer_interpreter_tb.sv
// self-checking bench of the path pointer interpreter
`timescale 1ns/1ns
`default_nettype none
module sonet_sdh_pointer_interpreter_tb
  import ptri_pkg::*;
;
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  ptri_apb_req_s req = '0;
  ptri_apb_rsp_s rsp;
  ptri_word_s    primary;
  ptri_word_s    conc;
  logic [1:0]    ci_class;
  logic [1:0]    ptr_state;
  logic          irq_a;
  logic          irq_b;
  logic [9:0]    cur = 10'h000;
  logic [31:0]   d;
  logic [31:0]   r;
  logic          e;
  logic          sdh = 1'b0;
  int            fails = 0;
  int            checks_done = 0;
  integer        seed = 32'h935f652b;

  always #50 clk = ~clk;

  ptri_core uut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .primary(primary),
    .conc(conc), .ci_class(ci_class), .ptr_state(ptr_state), .framer_irq_a(irq_a),
    .framer_irq_b(irq_b));
  ptri_far_end xm (.clk(clk), .primary(primary), .conc(conc));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v, d, e);
  endtask
  // pointer word with the ss field the current mode expects
  function automatic logic [15:0] pw(input logic [3:0] f, input logic [9:0] p);
    return {f, sdh ? SS_SDH : 2'h0, p};
  endfunction
  function automatic logic [9:0] nxt(input logic [9:0] p, input logic up);
    if (up) return (p == PTR_MAX) ? PTR_ZERO : p + 10'h001;
    return (p == PTR_ZERO) ? PTR_MAX : p - 10'h001;
  endfunction
  function automatic logic [31:0] ci_exp(input logic [15:0] w);
    logic [3:0] m;
    m = ~(w[15:12] ^ FLAG_NDF);
    if (w == AIS_WORD) return 32'(CI_AIS);
    if ($countones(m) >= 3 && w[9:0] == PTR_ONES && (!sdh || w[11:10] == SS_SDH))
      return 32'(CI_NORMAL);
    return 32'(CI_BAD);
  endfunction
  task automatic fr(input logic [15:0] w, input int n);
    repeat (n) xm.send(1'b0, w);
  endtask
  task automatic ci(input logic [15:0] w);
    xm.send(1'b1, w);
    chk({30'h0, ci_class}, ci_exp(w));
  endtask
  // pointer field is only meaningful while in normal state
  task automatic st(input logic [1:0] s);
    chk({30'h0, ptr_state}, {30'h0, s});
    xfer(1'b0, ADDR_STATE, 32'h0, d, e);
    chk(d & ((s == 2'h0) ? 32'hffffffff : 32'hfc00ffff),
        {6'h0, (s == 2'h0) ? cur : 10'h000, 14'h0, s});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    st(2'h1);
    rd(ADDR_PEND, 32'h0);
    wr(ADDR_MASK, 32'h4);
    rd(ADDR_MASK, 32'h4);
    cur = 10'h20a;
    fr({FLAG_NORM, 2'h1, cur}, 2);
    st(2'h1);
    fr({FLAG_NORM, 2'h1, cur}, 1);
    st(2'h0);
    chk({30'h0, irq_b, irq_a}, 32'h1);
    rd(ADDR_STAT, 32'h2);
    rd(ADDR_STAT, 32'h0);
    rd(ADDR_PEND, 32'h2);
    rd(ADDR_PEND, 32'h0);
    repeat (2) @(negedge clk);
    chk({31'h0, irq_a}, 32'h0);
    // random ndf, then an increment inside the hold window
    r = $random(seed);
    cur = 10'(r % 32'h30f);
    fr({FLAG_NDF, 2'h0, cur}, 1);
    st(2'h0);
    fr({FLAG_NORM, 2'h0, cur ^ I_MASK}, 1);
    st(2'h0);
    fr({FLAG_NORM, 2'h0, cur}, 2);
    fr({FLAG_NORM, 2'h0, cur ^ I_MASK}, 1);
    cur = nxt(cur, 1'b1);
    st(2'h0);
    fr({FLAG_NORM, 2'h0, cur}, 3);
    fr({FLAG_NORM, 2'h0, cur ^ D_MASK ^ 10'h00a}, 1);
    cur = nxt(cur, 1'b0);
    st(2'h0);
    fr({FLAG_NORM, 2'h0, cur}, 3);
    fr({FLAG_NORM, 2'h0, cur ^ I_MASK ^ 10'h015}, 1);
    st(2'h0);
    // sdh majority rules
    sdh = 1'b1;
    wr(ADDR_CTRL, 32'h1);
    fr(pw(FLAG_NORM, cur), 3);
    fr(pw(FLAG_NORM, cur ^ 10'h03f), 1);
    st(2'h0);
    fr(pw(FLAG_NORM, cur ^ 10'h02a), 1);
    cur = nxt(cur, 1'b1);
    st(2'h0);
    fr(pw(FLAG_NORM, cur), 3);
    fr(pw(FLAG_NORM, cur ^ 10'h01f), 1);
    cur = nxt(cur, 1'b0);
    st(2'h0);
    fr({FLAG_NORM, 2'h1, cur}, 7);
    st(2'h0);
    fr({FLAG_NORM, 2'h1, cur}, 1);
    st(2'h1);
    // alarm entry from loss of pointer
    wr(ADDR_MASK, 32'h2);
    fr(AIS_WORD, 2);
    st(2'h1);
    fr(AIS_WORD, 1);
    st(2'h2);
    repeat (2) @(negedge clk);
    chk({30'h0, irq_b, irq_a}, 32'h2);
    rd(ADDR_STAT, 32'h3);
    rd(ADDR_STAT, 32'h1);
    rd(ADDR_PEND, 32'h3);
    for (int i = 0; i < 8; i++) fr(pw(FLAG_NORM, 10'(i)), 1);
    st(2'h1);
    fr(AIS_WORD, 3);
    st(2'h2);
    r = $random(seed);
    cur = 10'(r % 32'h30f);
    fr(pw(FLAG_NDF, cur), 1);
    st(2'h0);
    // concatenation words
    ci(pw(FLAG_NDF, PTR_ONES));
    ci({4'hb, SS_SDH, PTR_ONES});
    ci({FLAG_NDF, 2'h0, PTR_ONES});
    ci(AIS_WORD);
    ci({4'hf, SS_SDH, PTR_ONES});
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      if (i == 6) begin
        sdh = 1'b0;
        wr(ADDR_CTRL, 32'h0);
      end
      ci({r[15:10], i[0] ? PTR_ONES : r[9:0]});
    end
    // unmapped address is refused
    xfer(1'b0, 8'h14, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    wrap_up;
  end

  // watchdog well beyond the expected run length
  initial begin
    #1000000;
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
